// >>> verilog/host_port_pkg.sv
package host_port_pkg;

  // ****************************************
  // core-side register offsets
  // ****************************************
  localparam logic [7:0] OFF_DATA0 = 8'h00;
  localparam logic [7:0] OFF_HOST_WRITTEN = 8'h18;
  localparam logic [7:0] OFF_CORE_WRITTEN = 8'h1C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
  localparam logic [7:0] OFF_PENDING = 8'h24;
  localparam logic [7:0] OFF_CONFIG = 8'h28;

  // ****************************************
  // mailbox layout
  // ****************************************
  localparam int NUM_DATA = 6;
  localparam int DATA_W = 16;
  localparam int HADDR_W = 3;
  localparam int ENTRY_W = HADDR_W + DATA_W;
  localparam logic [2:0] HADDR_STATUS_HOST = 3'h6;
  localparam logic [2:0] HADDR_STATUS_CORE = 3'h7;
  localparam int SOFT_RESET_BIT = 7;
  localparam logic [15:0] BYTE_MASK = 16'h00FF;
  localparam logic [15:0] WORD_MASK = 16'hFFFF;

  // ****************************************
  // config register fields
  // ****************************************
  localparam int CFG_WIDTH8_BIT = 0;
  localparam int CFG_DSTROBE_BIT = 1;
  localparam int CFG_MUX_BIT = 2;
  localparam int CFG_BOOT_HOST_BIT = 3;

  // ****************************************
  // reset values and timing
  // ****************************************
  localparam logic [5:0] MASK_RESET = 6'h00;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam int SOFT_RESET_CYCLES = 5;

  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_READ,
    HOST_WRITE
  } host_state_e;

endpackage : host_port_pkg

// >>> verilog/word_buffer.sv
`timescale 1ns/1ps
module word_buffer
  import host_port_pkg::*;
#(
  parameter int WIDTH = ENTRY_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
  } buf_s;

  buf_s state;
  buf_s next_state;
  logic do_push;
  logic do_pop;

  assign in_ready = (state.count != 2'd2);
  assign out_valid = (state.count != 2'd0);
  assign out_data = state.mem[state.rd_ptr];
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;

  always_comb begin
    next_state = state;
    if (do_push) begin
      next_state.mem[state.wr_ptr] = in_data;
      next_state.wr_ptr = ~state.wr_ptr;
    end
    if (do_pop) begin
      next_state.rd_ptr = ~state.rd_ptr;
    end
    if (do_push && !do_pop) begin
      next_state.count = state.count + 2'd1;
    end else if (!do_push && do_pop) begin
      next_state.count = state.count - 2'd1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

endmodule : word_buffer

// >>> verilog/soft_reset_pulse.sv
`timescale 1ns/1ps
module soft_reset_pulse
  import host_port_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request and pulse
  input wire logic start,
  output logic pulse
);

  typedef struct packed {
    logic [2:0] remaining;
    logic active;
  } pulse_s;

  pulse_s state;
  pulse_s next_state;

  assign pulse = state.active;

  always_comb begin
    next_state = state;
    if (start) begin
      next_state.remaining = 3'(SOFT_RESET_CYCLES - 1);
      next_state.active = 1'b1;
    end else if (state.active) begin
      if (state.remaining == 3'd0) begin
        next_state.active = 1'b0;
      end else begin
        next_state.remaining = state.remaining - 3'd1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

endmodule : soft_reset_pulse

// >>> verilog/host_mailbox_port.sv
`timescale 1ns/1ps
// How it works
// - width pin: low 16-bit, high 8-bit
// - boot pin: 0 byte memory, 1 host port
// - boot choice honoured only with map select 0
// - strobe pin: separate strobes or dir plus strobe
// - mux pin: separate buses or multiplexed with latch
// - separate mode: 3-bit address, 16-bit data
// - 8-bit reads drive only low byte
// - 8-bit host writes store zero upper byte
// - clockless host writes, safely buffered into core
// - mailbox readable and writable by core and host
// - address bit 2 doubles as latch enable
// - low address pins ignored when multiplexed
// - first strobe: read strobe or direction
// - second strobe: write strobe or data strobe
// - data pins bidirectional, address then data muxed
// - six data, two status, one mask register
// - host soft reset lasts five core cycles
module host_mailbox_port
  import host_port_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // configuration pins
  input wire logic HOST_WIDTH_SELECT,
  input wire logic BOOT_SOURCE_SELECT,
  input wire logic MEMORY_MAP_SELECT,
  input wire logic STROBE_STYLE_SELECT,
  input wire logic BUS_MULTIPLEX_SELECT,
  // host strobes and address
  input wire logic HOST_SELECT_N,
  input wire logic HOST_READ_STROBE_OR_DIR,
  input wire logic HOST_WRITE_OR_DATA_STROBE_N,
  input wire logic HOST_ADDR2_OR_LATCH,
  input wire logic [1:0] HOST_LOW_ADDRESS,
  // host data bus
  input wire logic [15:0] HOST_DATA_BUS_IN,
  output logic [15:0] HOST_DATA_BUS_OUT,
  output logic [15:0] HOST_DATA_BUS_OE,
  output logic HOST_PORT_ACK,
  // core-side status
  output logic BOOT_FROM_HOST,
  output logic SOFT_RESET
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [5:0] onehot6(input logic [2:0] idx);
    logic [5:0] v;
    v = 6'h00;
    if (idx < 3'(NUM_DATA)) begin
      v[idx] = 1'b1;
    end
    return v;
  endfunction : onehot6

  function automatic logic [15:0] host_narrow(input logic width8, input logic [15:0] d);
    return width8 ? (d & BYTE_MASK) : d;
  endfunction : host_narrow

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [NUM_DATA-1:0][DATA_W-1:0] mailbox;
    logic [5:0] host_written;
    logic [5:0] core_written;
    logic [5:0] irq_mask;
    host_state_e host_state;
    logic [2:0] latched_addr;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] dout;
    logic [15:0] doe;
    logic ack;
    logic boot_from_host;
    logic push;
    logic [ENTRY_W-1:0] push_entry;
  } port_s;

  port_s state;
  port_s next_state;

  logic buf_in_ready;
  logic buf_out_valid;
  logic [ENTRY_W-1:0] buf_out_data;
  logic buf_out_ready;
  logic soft_reset_start;

  // ****************************************
  // host pin decode
  // ****************************************
  logic host_sel;
  logic host_rd;
  logic host_wr;
  logic [2:0] host_addr;
  logic width8;

  assign host_sel = !HOST_SELECT_N;
  assign width8 = HOST_WIDTH_SELECT;
  always_comb begin
    if (STROBE_STYLE_SELECT) begin
      host_rd = !HOST_WRITE_OR_DATA_STROBE_N && HOST_READ_STROBE_OR_DIR;
      host_wr = !HOST_WRITE_OR_DATA_STROBE_N && !HOST_READ_STROBE_OR_DIR;
    end else begin
      host_rd = !HOST_READ_STROBE_OR_DIR;
      host_wr = !HOST_WRITE_OR_DATA_STROBE_N;
    end
    if (BUS_MULTIPLEX_SELECT) begin
      host_addr = state.latched_addr;
    end else begin
      host_addr = {HOST_ADDR2_OR_LATCH, HOST_LOW_ADDRESS};
    end
  end

  // ****************************************
  // apb decode
  // ****************************************
  logic apb_setup;
  logic apb_access;
  logic apb_wr;
  logic apb_rd;
  logic [2:0] apb_idx;
  logic apb_is_data;
  logic apb_mapped;

  assign apb_setup = PSEL && !PENABLE && !state.pready;
  assign apb_access = PSEL && PENABLE && state.pready;
  assign apb_wr = apb_access && PWRITE && apb_mapped;
  assign apb_rd = apb_access && !PWRITE && apb_mapped;
  assign apb_idx = PADDR[4:2];
  assign apb_is_data = (PADDR[1:0] == 2'b00) && (PADDR < OFF_HOST_WRITTEN);
  always_comb begin
    apb_mapped = apb_is_data;
    unique case (PADDR)
      OFF_HOST_WRITTEN, OFF_CORE_WRITTEN, OFF_IRQ_MASK, OFF_PENDING, OFF_CONFIG: begin
        apb_mapped = 1'b1;
      end
      default: begin
      end
    endcase
  end

  // core writes win the mailbox; a buffered host word waits a cycle
  assign buf_out_ready = !apb_wr;

  // ****************************************
  // host-written word buffer
  // ****************************************
  word_buffer #(
    .WIDTH(ENTRY_W)
  ) u_buffer (
    .clk(REF_CLK),
    .rst(RESET),
    .in_valid(state.push),
    .in_data(state.push_entry),
    .in_ready(buf_in_ready),
    .out_valid(buf_out_valid),
    .out_data(buf_out_data),
    .out_ready(buf_out_ready)
  );

  logic drain;
  logic [2:0] drain_addr;
  logic [15:0] drain_data;

  // one buffered host word reaches the mailbox per free cycle
  assign drain = buf_out_valid && buf_out_ready;
  assign drain_addr = buf_out_data[ENTRY_W-1:DATA_W];
  assign drain_data = buf_out_data[DATA_W-1:0];
  assign soft_reset_start = drain && (drain_addr == HADDR_STATUS_CORE)
                            && drain_data[SOFT_RESET_BIT];

  soft_reset_pulse u_soft_reset (
    .clk(REF_CLK),
    .rst(RESET),
    .start(soft_reset_start),
    .pulse(SOFT_RESET)
  );

  // ****************************************
  // read multiplexers
  // ****************************************
  logic [15:0] host_read_value;
  logic [31:0] apb_read_value;

  always_comb begin
    host_read_value = 16'h0000;
    if (host_addr < 3'(NUM_DATA)) begin
      host_read_value = state.mailbox[host_addr];
    end else if (host_addr == HADDR_STATUS_HOST) begin
      host_read_value = {10'h000, state.host_written};
    end else begin
      host_read_value = {10'h000, state.core_written};
    end
  end

  always_comb begin
    apb_read_value = 32'h0000_0000;
    if (apb_is_data) begin
      apb_read_value = {16'h0000, state.mailbox[apb_idx]};
    end else begin
      unique case (PADDR)
        OFF_HOST_WRITTEN: apb_read_value = {26'h0, state.host_written};
        OFF_CORE_WRITTEN: apb_read_value = {26'h0, state.core_written};
        OFF_IRQ_MASK: apb_read_value = {26'h0, state.irq_mask};
        OFF_PENDING: apb_read_value = {26'h0, state.host_written & state.irq_mask};
        OFF_CONFIG: begin
          apb_read_value[CFG_WIDTH8_BIT] = HOST_WIDTH_SELECT;
          apb_read_value[CFG_DSTROBE_BIT] = STROBE_STYLE_SELECT;
          apb_read_value[CFG_MUX_BIT] = BUS_MULTIPLEX_SELECT;
          apb_read_value[CFG_BOOT_HOST_BIT] = state.boot_from_host;
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // next state
  // ****************************************
  logic [5:0] host_set;
  logic [5:0] host_clr;
  logic [5:0] core_set;
  logic [5:0] core_clr;

  always_comb begin
    next_state = state;
    host_set = 6'h00;
    host_clr = 6'h00;
    core_set = 6'h00;
    core_clr = 6'h00;
    next_state.push = 1'b0;

    next_state.boot_from_host = !MEMORY_MAP_SELECT && BOOT_SOURCE_SELECT;

    if (BUS_MULTIPLEX_SELECT && HOST_ADDR2_OR_LATCH) begin
      next_state.latched_addr = HOST_DATA_BUS_IN[2:0];
    end

    // apb slave: no wait state, answer on the first access cycle
    next_state.pready = apb_setup;
    if (apb_setup) begin
      next_state.prdata = PWRITE ? 32'h0000_0000 : apb_read_value;
      next_state.pslverr = !apb_mapped;
    end else if (!PSEL) begin
      next_state.pslverr = 1'b0;
    end

    if (apb_wr) begin
      if (apb_is_data) begin
        next_state.mailbox[apb_idx] = PWDATA[15:0];
        core_set = onehot6(apb_idx);
      end else if (PADDR == OFF_IRQ_MASK) begin
        next_state.irq_mask = PWDATA[5:0];
      end else if (PADDR == OFF_HOST_WRITTEN) begin
        host_clr = PWDATA[5:0];
      end
    end
    if (apb_rd && apb_is_data) begin
      host_clr = host_clr | onehot6(apb_idx);
    end

    if (drain && (drain_addr < 3'(NUM_DATA))) begin
      next_state.mailbox[drain_addr] = drain_data;
      host_set = onehot6(drain_addr);
    end

    // host access sequencing
    unique case (state.host_state)
      HOST_IDLE: begin
        if (host_sel && host_rd) begin
          next_state.dout = host_read_value;
          next_state.doe = width8 ? BYTE_MASK : WORD_MASK;
          next_state.ack = 1'b1;
          core_clr = onehot6(host_addr);
          next_state.host_state = HOST_READ;
        end else if (host_sel && host_wr && buf_in_ready) begin
          next_state.push = 1'b1;
          next_state.push_entry = {host_addr, host_narrow(width8, HOST_DATA_BUS_IN)};
          next_state.ack = 1'b1;
          next_state.host_state = HOST_WRITE;
        end
      end
      HOST_READ, HOST_WRITE: begin
        // release one cycle after the host lets go of its strobe
        if (!(host_sel && (host_rd || host_wr))) begin
          next_state.ack = 1'b0;
          next_state.doe = 16'h0000;
          next_state.dout = 16'h0000;
          next_state.host_state = HOST_IDLE;
        end
      end
      default: begin
        // unused state code: drop the bus and wait for a new access
        next_state.ack = 1'b0;
        next_state.doe = 16'h0000;
        next_state.host_state = HOST_IDLE;
      end
    endcase

    // a set in the same cycle as its clear wins
    next_state.host_written = (state.host_written & ~host_clr) | host_set;
    next_state.core_written = (state.core_written & ~core_clr) | core_set;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      state <= '0;
      state.irq_mask <= MASK_RESET;
      state.host_state <= HOST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign PRDATA = state.prdata;
  assign PREADY = state.pready;
  assign PSLVERR = state.pslverr;
  assign HOST_DATA_BUS_OUT = state.dout;
  assign HOST_DATA_BUS_OE = state.doe;
  assign HOST_PORT_ACK = state.ack;
  assign BOOT_FROM_HOST = state.boot_from_host;

endmodule : host_mailbox_port

// >>> sim/host_mailbox_port_monitor.sv
`timescale 1ns/1ps
module host_mailbox_port_monitor
  import host_port_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [7:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // host side
  input wire logic HOST_WIDTH_SELECT,
  input wire logic BOOT_SOURCE_SELECT,
  input wire logic MEMORY_MAP_SELECT,
  input wire logic STROBE_STYLE_SELECT,
  input wire logic HOST_SELECT_N,
  input wire logic HOST_READ_STROBE_OR_DIR,
  input wire logic [15:0] HOST_DATA_BUS_OE,
  input wire logic HOST_PORT_ACK,
  input wire logic BOOT_FROM_HOST,
  input wire logic SOFT_RESET
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);
  // ********
  // checks
  // ********
  chk_read_lanes: assert property (HOST_DATA_BUS_OE != 16'h0000 |->
    HOST_DATA_BUS_OE == (HOST_WIDTH_SELECT ? 16'h00FF : 16'hFFFF)) else $error("bad lanes");
  chk_drive_with_ack: assert property (HOST_DATA_BUS_OE != 16'h0000 |-> HOST_PORT_ACK)
    else $error("drive without ack");
  chk_ack_needs_select: assert property ($rose(HOST_PORT_ACK) |-> $past(!HOST_SELECT_N))
    else $error("ack without select");
  chk_ack_release: assert property (HOST_PORT_ACK && HOST_SELECT_N |-> ##[1:2] !HOST_PORT_ACK)
    else $error("ack stuck");
  chk_read_accept: assert property (!HOST_SELECT_N && !STROBE_STYLE_SELECT &&
    !HOST_READ_STROBE_OR_DIR && !HOST_PORT_ACK |-> ##[1:2] HOST_PORT_ACK) else $error("no ack");
  chk_boot_source: assert property (!$past(RESET) |->
    BOOT_FROM_HOST == $past(!MEMORY_MAP_SELECT && BOOT_SOURCE_SELECT)) else $error("bad boot");
  chk_soft_length: assert property ($rose(SOFT_RESET) |-> SOFT_RESET [*5] ##1 !SOFT_RESET)
    else $error("bad soft reset length");
  chk_ready_pulse: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
    else $error("bad ready");
  chk_unmapped_error: assert property (PSEL && PENABLE && PREADY && PADDR > OFF_CONFIG |->
    PSLVERR) else $error("no slave error");
  cover property ($rose(SOFT_RESET));
  cover property (PREADY && PSLVERR);
  cover property (HOST_DATA_BUS_OE == 16'h00FF);
endmodule : host_mailbox_port_monitor

bind host_mailbox_port host_mailbox_port_monitor mon (.*);

// >>> sim/host_bus_model.sv
`timescale 1ns/1ps
module host_bus_model (
  // clock and configuration
  input wire logic clk,
  input wire logic width8,
  input wire logic dstrobe,
  input wire logic muxed,
  // strobes and address
  output logic sel_n,
  output logic rd_dir,
  output logic wr_ds_n,
  output logic addr2_latch,
  output logic [1:0] low_addr,
  // data wires
  output logic [15:0] bus,
  input wire logic [15:0] dev_out,
  input wire logic [15:0] dev_oe,
  input wire logic ack
);
  logic drive = 1'b0;
  logic [15:0] dat = 16'h0000;
  logic [15:0] noise = 16'h0000;
  logic [15:0] lanes;
  int timeouts = 0;
  // released wires toggle every cycle
  always @(posedge clk) noise <= ~noise;
  assign lanes = drive ? (width8 ? 16'h00FF : 16'hFFFF) : 16'h0000;
  assign bus = (dev_oe & dev_out) | (~dev_oe & lanes & dat) | (~dev_oe & ~lanes & noise);
  initial begin
    sel_n = 1'b1;
    rd_dir = 1'b1;
    wr_ds_n = 1'b1;
    addr2_latch = 1'b0;
    low_addr = 2'h0;
  end
  task automatic access(input logic wr, input logic [2:0] a, input logic [15:0] d);
    int n;
    if (muxed) begin
      addr2_latch <= 1'b1;
      drive <= 1'b1;
      dat <= {13'h0000, a};
      @(posedge clk);
    end
    sel_n <= 1'b0;
    addr2_latch <= muxed ? 1'b0 : a[2];
    low_addr <= muxed ? ~a[1:0] : a[1:0];
    rd_dir <= dstrobe ? !wr : wr;
    wr_ds_n <= dstrobe ? 1'b0 : !wr;
    drive <= wr;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n == 20) timeouts++;
    sel_n <= 1'b1;
    rd_dir <= 1'b1;
    wr_ds_n <= 1'b1;
    drive <= 1'b0;
    n = 0;
    while (ack !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) timeouts++;
  endtask : access
endmodule : host_bus_model

// >>> sim/testbench.sv
`timescale 1ns/1ps
`define CHECK(got, exp) begin logic [63:0] seen, want; seen = 64'(got); want = 64'(exp); \
  comparisons++; if (seen !== want) begin fails++; \
  $display("BAD t=%0t got %h exp %h", $time, seen, want); end end
module testbench;
  import host_port_pkg::*;
  logic REF_CLK = 1'b0;
  logic RESET = 1'b1;
  logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic PREADY, PSLVERR, HOST_PORT_ACK, BOOT_FROM_HOST, SOFT_RESET, ack_q;
  logic HOST_WIDTH_SELECT = 1'b0, BOOT_SOURCE_SELECT = 1'b0, MEMORY_MAP_SELECT = 1'b0;
  logic STROBE_STYLE_SELECT = 1'b0, BUS_MULTIPLEX_SELECT = 1'b0;
  logic HOST_SELECT_N, HOST_READ_STROBE_OR_DIR, HOST_WRITE_OR_DATA_STROBE_N;
  logic HOST_ADDR2_OR_LATCH;
  logic [1:0] HOST_LOW_ADDRESS;
  logic [15:0] HOST_DATA_BUS_IN, HOST_DATA_BUS_OUT, HOST_DATA_BUS_OE;
  int fails = 0, comparisons = 0, sr_len = 0;
  logic [32:0] apbq[$];
  logic [31:0] hostq[$];
  int srq[$];
  logic [31:0] host_seen;

  assign host_seen = {HOST_DATA_BUS_OE, HOST_DATA_BUS_OUT & HOST_DATA_BUS_OE};

  host_mailbox_port uut (.*);
  host_bus_model hm (.clk(REF_CLK), .width8(HOST_WIDTH_SELECT),
    .dstrobe(STROBE_STYLE_SELECT), .muxed(BUS_MULTIPLEX_SELECT), .sel_n(HOST_SELECT_N),
    .rd_dir(HOST_READ_STROBE_OR_DIR), .wr_ds_n(HOST_WRITE_OR_DATA_STROBE_N),
    .addr2_latch(HOST_ADDR2_OR_LATCH), .low_addr(HOST_LOW_ADDRESS), .bus(HOST_DATA_BUS_IN),
    .dev_out(HOST_DATA_BUS_OUT), .dev_oe(HOST_DATA_BUS_OE), .ack(HOST_PORT_ACK));

  initial begin
    forever #25 REF_CLK = ~REF_CLK;
  end

  // ********
  // drivers
  // ********
  task automatic print_verdict();
    if (fails == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    int n;
    apbq.push_back(exp);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n == 20) begin
      fails++;
      print_verdict();
    end
  endtask : apb

  task automatic apb_idle();
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge REF_CLK);
  endtask : apb_idle

  task automatic host(input logic w, input logic [2:0] a, input logic [15:0] d,
                      input logic [15:0] exp);
    hostq.push_back(w ? 32'h0 : {HOST_WIDTH_SELECT ? BYTE_MASK : WORD_MASK, exp});
    hm.access(w, a, d);
    if (hm.timeouts != 0) begin
      fails++;
      print_verdict();
    end
  endtask : host

  // ********
  // result watcher
  // ********
  always @(posedge REF_CLK) begin
    ack_q <= HOST_PORT_ACK;
    if (PSEL && PENABLE && PREADY === 1'b1)
      `CHECK({PSLVERR, PRDATA}, (apbq.size() ? apbq.pop_front() : 'x))
    if (HOST_PORT_ACK === 1'b1 && ack_q !== 1'b1)
      `CHECK(host_seen, (hostq.size() ? hostq.pop_front() : 'x))
    if (SOFT_RESET === 1'b1) begin
      sr_len++;
    end else if (sr_len != 0) begin
      `CHECK(sr_len, (srq.size() ? srq.pop_front() : 0))
      sr_len = 0;
    end
  end

  // ********
  // scenarios
  // ********
  initial begin
    logic [15:0] d, e, lanes;
    logic [2:0] a, b;
    int n;
    n = $urandom(42);
    for (int cfg = 0; cfg < 8; cfg++) begin
      RESET <= 1'b1;
      {BUS_MULTIPLEX_SELECT, STROBE_STYLE_SELECT, HOST_WIDTH_SELECT} <= cfg[2:0];
      {MEMORY_MAP_SELECT, BOOT_SOURCE_SELECT} <= 2'($urandom);
      repeat (3) @(posedge REF_CLK);
      RESET <= 1'b0;
      lanes = cfg[0] ? BYTE_MASK : WORD_MASK;
      a = 3'($urandom_range(5));
      b = 3'((a + 1) % 6);
      d = 16'($urandom);
      e = 16'($urandom);
      host(1'b1, a, d, 16'h0000);
      apb(1'b0, 8'(4 * a), 32'h0, {17'h0, d & lanes});
      apb(1'b1, 8'(4 * b), {16'h0000, e}, 33'h0);
      apb(1'b0, OFF_CONFIG, 32'h0, {29'h0, !MEMORY_MAP_SELECT && BOOT_SOURCE_SELECT, 3'(cfg)});
      apb(1'b0, 8'hFC, 32'h0, {1'b1, 32'h0});
      apb_idle();
      host(1'b0, HADDR_STATUS_CORE, 16'h0000, 16'h0001 << b);
      host(1'b0, b, 16'h0000, e & lanes);
      fork
        for (int i = 0; i < 3; i++) host(1'b1, 3'(i), e ^ 16'(i), 16'h0000);
        begin
          for (int i = 0; i < 6; i++) apb(1'b1, OFF_IRQ_MASK, 32'(i), 33'h0);
          apb_idle();
        end
      join
      host(1'b0, HADDR_STATUS_HOST, 16'h0000, 16'h0007);
      apb(1'b1, OFF_HOST_WRITTEN, 32'h1, 33'h0);
      apb(1'b0, OFF_PENDING, 32'h0, 33'h4);
      for (int i = 0; i < 3; i++) apb(1'b0, 8'(4 * i), 32'h0, {17'h0, (e ^ 16'(i)) & lanes});
      apb(1'b0, OFF_IRQ_MASK, 32'h0, 33'h5);
      apb_idle();
      host(1'b1, HADDR_STATUS_CORE, 16'h0080, 16'h0000);
      srq.push_back(5);
      n = 0;
      while (srq.size() != 0 && n < 20) begin
        @(posedge REF_CLK);
        n++;
      end
      if (n == 20) begin
        fails++;
        print_verdict();
      end
    end
    `CHECK(apbq.size() + hostq.size(), 0)
    print_verdict();
  end
endmodule : testbench
